/* File: crs_pkg.sv */
/*
 * Package of the core register set: field positions, reset values,
 * register-space offset of the flags byte and the command encodings.
 * Assumes a single clock domain shared with the instruction sequencer.
 */
package crs_pkg;

    // Data path widths
    localparam int CRS_DW = 8;
    localparam int CRS_PW = 16;

    // Register-space offset of the flags byte
    localparam logic [7:0] CRS_FLAGS_ADDR = 8'hf7;

    // Flags field positions
    localparam int CRS_F_GIE = 0;
    localparam int CRS_F_ZERO = 1;
    localparam int CRS_F_CARRY = 2;
    localparam int CRS_F_SUPER = 3;
    localparam int CRS_F_BANK = 4;

    // Bits that user-level flag instructions may change
    localparam logic [7:0] CRS_F_USER_MASK = 8'h17;
    // Bits that supervisor-level flag instructions may change
    localparam logic [7:0] CRS_F_SUP_MASK = 8'h1f;

    // Reset values
    localparam logic [7:0] CRS_RST_FLAGS = 8'h02;
    localparam logic [7:0] CRS_RST_ACC = 8'h00;
    localparam logic [7:0] CRS_RST_IDX = 8'h00;
    localparam logic [7:0] CRS_RST_SP = 8'h00;
    localparam logic [15:0] CRS_RST_PC = 16'h0000;

    // Stack step sizes in bytes
    localparam logic [7:0] CRS_SP_STEP_BYTE = 8'h01;
    localparam logic [7:0] CRS_SP_STEP_CALL = 8'h02;
    localparam logic [7:0] CRS_SP_STEP_RETURN_FROM_INTERRUPT_INSTRUCTION = 8'h03;

    // Arithmetic and logic operations
    typedef enum logic [3:0] {
        CRS_OP_MOV = 4'h0,
        CRS_OP_ADD = 4'h1,
        CRS_OP_ADC = 4'h2,
        CRS_OP_SUB = 4'h3,
        CRS_OP_SBB = 4'h4,
        CRS_OP_AND = 4'h5,
        CRS_OP_OR = 4'h6,
        CRS_OP_XOR = 4'h7,
        CRS_OP_ASL = 4'h8,
        CRS_OP_ASR = 4'h9,
        CRS_OP_RLC = 4'ha,
        CRS_OP_RRC = 4'hb
    } crs_op_t;

    // Destination of an operation result
    typedef enum logic [1:0] {
        CRS_DST_NONE = 2'h0,
        CRS_DST_ACC = 2'h1,
        CRS_DST_IDX = 2'h2,
        CRS_DST_SP = 2'h3
    } crs_dst_t;

    // Stack pointer actions
    typedef enum logic [2:0] {
        CRS_SP_HOLD = 3'h0,
        CRS_SP_PUSH = 3'h1,
        CRS_SP_POP = 3'h2,
        CRS_SP_CALL = 3'h3,
        CRS_SP_RET = 3'h4,
        CRS_SP_RETURN_FROM_INTERRUPT_INSTRUCTION = 3'h5
    } crs_sp_act_t;

    // One execute step from the sequencer
    typedef struct packed {
        logic valid;
        crs_op_t op;
        crs_dst_t dst;
        logic set_flags;
        logic [7:0] src_a;
        logic [7:0] src_b;
    } crs_exec_t;

    // Program counter step
    typedef struct packed {
        logic load;
        logic [15:0] target;
        logic advance;
        logic [1:0] length;
    } crs_pc_cmd_t;

    // Flags result of an operation
    typedef struct packed {
        logic carry;
        logic zero;
    } crs_cz_t;

endpackage

/* File: crs_alu.sv */
/*
 * Eight-bit arithmetic and logic unit of the core register set.
 * Purely combinational; assumes the caller registers the result.
 */
`timescale 1ns/1ns
`default_nettype none

module crs_alu
    import crs_pkg::*;
(
    // Operation
    input wire crs_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic carry_i,
    // Result
    output logic [7:0] res_o,
    output crs_cz_t cz_o
);

    ////////////////////////////////////////////////////////////////////////
    // Nine-bit results, bit 8 is the carry out
    wire logic [8:0] sum_w = {1'b0, a_i} + {1'b0, b_i};
    wire logic [8:0] sumc_w = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i};
    wire logic [8:0] dif_w = {1'b0, a_i} - {1'b0, b_i};
    wire logic [8:0] difc_w = {1'b0, a_i} - {1'b0, b_i} - {8'h00, carry_i};
    logic [8:0] wide;

    // Operation select
    always_comb begin
        wide = {1'b0, b_i};
        case (op_i)
            CRS_OP_ADD: wide = sum_w;
            CRS_OP_ADC: wide = sumc_w;
            CRS_OP_SUB: wide = dif_w;
            CRS_OP_SBB: wide = difc_w;
            CRS_OP_AND: wide = {1'b0, a_i & b_i};
            CRS_OP_OR: wide = {1'b0, a_i | b_i};
            CRS_OP_XOR: wide = {1'b0, a_i ^ b_i};
            CRS_OP_ASL: wide = {a_i, 1'b0};
            CRS_OP_ASR: wide = {a_i[0], a_i[7], a_i[7:1]};
            CRS_OP_RLC: wide = {a_i, carry_i};
            CRS_OP_RRC: wide = {a_i[0], carry_i, a_i[7:1]};
            default: wide = {1'b0, b_i};
        endcase
    end

    // Result and condition bits
    assign res_o = wide[7:0];
    assign cz_o.carry = wide[8];
    assign cz_o.zero = (wide[7:0] == 8'h00);

endmodule

`default_nettype wire

/* File: crs_pc.sv */
/*
 * Sixteen-bit program counter of the core register set.
 * Assumes one load or advance command per cycle from the sequencer.
 */
`timescale 1ns/1ns
`default_nettype none

module crs_pc
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Command
    input wire crs_pc_cmd_t cmd_i,
    // Count
    output logic [15:0] pc_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] pc_q;
    logic [15:0] pc_d;

    assign pc_d = cmd_i.load ? cmd_i.target :
                  cmd_i.advance ? pc_q + {14'h0000, cmd_i.length} : pc_q;

    // Counter register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pc_q <= CRS_RST_PC;
        end else begin
            pc_q <= pc_d;
        end
    end

    assign pc_o = pc_q;

endmodule

`default_nettype wire

/* File: crs_core_regs.sv */
/*
 * Architectural register set of an 8-bit Harvard core: accumulator,
 * index, stack pointer, program counter and flags, with the flags byte
 * readable in register space. Assumes a sequencer on the same clock
 * that issues execute, stack, program counter and flag commands.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Five core registers updated by instructions, not ordinary register-space locations.
// - Eight-bit Harvard core; program and data address spaces stay separate.
// - Sixteen-bit program counter reaches all sixty-four kilobytes of program memory.
// - Program counter shows as high byte 15:8 and low byte 7:0.
// - Accumulator takes result of logic or arithmetic using source addressing.
// - Index register supplies the offset for indexed addressing.
// - Stack pointer holds data-memory address of the top of stack.
// - Push, pop, calls, returns change stack pointer; swap and add may too.
// - Flags: interrupt enable bit 0, zero 1, carry 2, supervisor 3.
// - Supervisor bit cannot be changed by user code.
// - Supervisor bit reads 0 in user code, 1 in supervisor code.
// - Arithmetic, logic and shift instructions update flags per instruction.
// - Carry is 1 after an operation that produced carry, else 0.
// - Zero is 1 after a zero result, else 0.
// - Interrupt enable bit 0 blocks all interrupts, 1 permits them.
// - Flags bit 4 is user-writable bank select, 0 bank 0, 1 bank 1.
// - Flags register reads at register-space address f7.

module crs_core_regs
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,

    // Execute step
    input wire crs_exec_t exec_i,

    // Stack pointer action
    input wire crs_sp_act_t sp_act_i,

    // Program counter command
    input wire crs_pc_cmd_t pc_cmd_i,

    // Flag instructions and privilege changes
    input wire logic flag_and_i,
    input wire logic flag_or_i,
    input wire logic [7:0] flag_operand_i,
    input wire logic super_enter_i,
    input wire logic super_exit_i,

    // Register-space read
    input wire logic rd_en_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic rd_hit_o,

    // Register views
    output logic [7:0] acc_o,
    output logic [7:0] idx_o,
    output logic [7:0] sp_o,
    output logic [7:0] pc_high_o,
    output logic [7:0] pc_low_o,
    output logic [7:0] flags_o,

    // Core-wide controls
    output logic global_interrupt_enable_o,
    output logic register_bank_select_o,
    output logic super_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    // Data registers
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic [7:0] idx_q;
    logic [7:0] idx_d;
    logic [7:0] sp_q;
    logic [7:0] sp_d;

    // Flags byte
    logic [7:0] flags_q;
    logic [7:0] flags_d;

    // Read answer
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rd_hit_q;
    logic rd_hit_d;

    // Program counter and its byte copies
    logic [15:0] pc_w;
    logic [7:0] pc_high_q;
    logic [7:0] pc_low_q;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Merge masked bits of a new value into an old one
    function automatic logic [7:0] crs_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask);
        crs_merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Stack step for an action
    function automatic logic [7:0] crs_sp_step(input crs_sp_act_t act);
        case (act)
            CRS_SP_PUSH, CRS_SP_POP: crs_sp_step = CRS_SP_STEP_BYTE;
            CRS_SP_CALL, CRS_SP_RET: crs_sp_step = CRS_SP_STEP_CALL;
            CRS_SP_RETURN_FROM_INTERRUPT_INSTRUCTION: crs_sp_step = CRS_SP_STEP_RETURN_FROM_INTERRUPT_INSTRUCTION;
            default: crs_sp_step = 8'h00;
        endcase
    endfunction

    // Execute step that writes a given destination
    function automatic logic crs_dst_hit(input crs_exec_t ex, input crs_dst_t dst);
        crs_dst_hit = ex.valid && (ex.dst == dst);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic unit

    logic [7:0] alu_res_w;
    crs_cz_t alu_cz_w;

    // Carry in comes from the flags byte, so carry chains span steps
    crs_alu crs_alu_i (
        .op_i(exec_i.op),
        .a_i(exec_i.src_a),
        .b_i(exec_i.src_b),
        .carry_i(flags_q[CRS_F_CARRY]),
        .res_o(alu_res_w),
        .cz_o(alu_cz_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Program counter

    // Counter lives in its own module; the bytes below are registered copies
    // separate program address
    crs_pc crs_pc_i (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .cmd_i(pc_cmd_i),
        .pc_o(pc_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Destination decode

    // One destination per step; no destination leaves only the flags to update
    wire logic wr_acc_w = crs_dst_hit(exec_i, CRS_DST_ACC);
    wire logic wr_idx_w = crs_dst_hit(exec_i, CRS_DST_IDX);
    wire logic wr_sp_w = crs_dst_hit(exec_i, CRS_DST_SP);
    // Carry and zero follow any valid step that asks for them
    wire logic upd_cz_w = exec_i.valid && exec_i.set_flags;
    // Stack direction from the action code
    wire logic sp_up_w = (sp_act_i == CRS_SP_PUSH) || (sp_act_i == CRS_SP_CALL);
    wire logic sp_down_w = (sp_act_i == CRS_SP_POP) || (sp_act_i == CRS_SP_RET) ||
                           (sp_act_i == CRS_SP_RETURN_FROM_INTERRUPT_INSTRUCTION);
    wire logic rd_flags_w = rd_en_i && (rd_addr_i == CRS_FLAGS_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // Data registers next values

    assign acc_d = wr_acc_w ? alu_res_w : acc_q;

    assign idx_d = wr_idx_w ? alu_res_w : idx_q;

    // A stack pointer load beats any stack action; the pointer wraps
    // stack pointer moves
    assign sp_d = wr_sp_w ? alu_res_w :
                  sp_up_w ? sp_q + crs_sp_step(sp_act_i) :
                  sp_down_w ? sp_q - crs_sp_step(sp_act_i) : sp_q;

    ////////////////////////////////////////////////////////////////////////
    // Flags next value

    logic [7:0] fl_and_w;
    logic [7:0] fl_or_w;
    logic [7:0] fl_mask_w;
    logic [7:0] fl_cz_w;
    logic [7:0] fl_sw_w;

    // Mask follows the privilege held before this edge
    // user cannot touch supervisor
    assign fl_mask_w = flags_q[CRS_F_SUPER] ? CRS_F_SUP_MASK : CRS_F_USER_MASK;

    // AND and OR flag instructions edit the masked flags bits
    assign fl_and_w = crs_merge(flags_q, flags_q & flag_operand_i, fl_mask_w);
    assign fl_or_w = crs_merge(flags_q, flags_q | flag_operand_i, fl_mask_w);
    assign fl_sw_w = flag_and_i ? fl_and_w : flag_or_i ? fl_or_w : flags_q;

    // Flag instruction first; an operation in the same step then owns carry and zero
    // operation updates carry and zero
    assign fl_cz_w = upd_cz_w ?
                     {fl_sw_w[7:3], alu_cz_w.carry, alu_cz_w.zero, fl_sw_w[CRS_F_GIE]} : fl_sw_w;

    // Entry beats exit and any flag instruction; bits 7:5 stay 0
    // privilege entry and exit
    assign flags_d = {3'b000, fl_cz_w[CRS_F_BANK],
                      super_enter_i ? 1'b1 : super_exit_i ? 1'b0 : fl_cz_w[CRS_F_SUPER],
                      fl_cz_w[2:0]};

    ////////////////////////////////////////////////////////////////////////
    // Register-space read port

    // Answer shows flags as they stood before this edge
    // flags at f7
    assign rd_data_d = rd_flags_w ? flags_q : 8'h00;
    assign rd_hit_d = rd_flags_w;

    ////////////////////////////////////////////////////////////////////////
    // Data registers

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            acc_q <= CRS_RST_ACC;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            idx_q <= CRS_RST_IDX;
        end else begin
            idx_q <= idx_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sp_q <= CRS_RST_SP;
        end else begin
            sp_q <= sp_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flags_q <= CRS_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Byte copies lag the counter one cycle but both halves move together
    // split program counter bytes
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pc_high_q <= CRS_RST_PC[15:8];
            pc_low_q <= CRS_RST_PC[7:0];
        end else begin
            pc_high_q <= pc_w[15:8];
            pc_low_q <= pc_w[7:0];
        end
    end

    // Registered read answer
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 8'h00;
            rd_hit_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_hit_q <= rd_hit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    // Register views
    assign acc_o = acc_q;
    assign idx_o = idx_q;
    assign sp_o = sp_q;
    assign pc_high_o = pc_high_q;
    assign pc_low_o = pc_low_q;
    assign flags_o = flags_q;

    // Core-wide control levels
    // interrupt gate level
    assign global_interrupt_enable_o = flags_q[CRS_F_GIE];
    assign register_bank_select_o = flags_q[CRS_F_BANK];
    assign super_o = flags_q[CRS_F_SUPER];

    // Read answer
    assign rd_data_o = rd_data_q;
    assign rd_hit_o = rd_hit_q;

endmodule

`default_nettype wire

/* File: crs_core_regs_properties.sv */
/* Port checker of the core register set.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module crs_core_regs_properties
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Commands
    input wire crs_exec_t exec_i,
    input wire crs_sp_act_t sp_act_i,
    input wire crs_pc_cmd_t pc_cmd_i,
    input wire logic flag_and_i,
    input wire logic flag_or_i,
    input wire logic [7:0] flag_operand_i,
    input wire logic super_enter_i,
    input wire logic super_exit_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rd_addr_i,
    // Results
    input wire logic [7:0] rd_data_o,
    input wire logic rd_hit_o,
    input wire logic [7:0] acc_o,
    input wire logic [7:0] idx_o,
    input wire logic [7:0] sp_o,
    input wire logic [7:0] pc_high_o,
    input wire logic [7:0] pc_low_o,
    input wire logic [7:0] flags_o,
    input wire logic global_interrupt_enable_o,
    input wire logic register_bank_select_o,
    input wire logic super_o
);
default clocking @(posedge clk_sys_i);
endclocking
default disable iff (!rst_n_i);
////////////////////////////////////////////////////////////
// Decoded command helpers
wire logic acc_wr = exec_i.valid && exec_i.dst == CRS_DST_ACC;
wire logic sp_ld = exec_i.valid && exec_i.dst == CRS_DST_SP;
wire logic rd_flags = rd_en_i && rd_addr_i == CRS_FLAGS_ADDR;
wire logic [8:0] add_sum = {1'b0, exec_i.src_a} + {1'b0, exec_i.src_b};
////////////////////////////////////////////////////////////
// Assertions
a_read_flags_hit: assert property (rd_flags |=> rd_hit_o && rd_data_o == $past(flags_o))
    else $error("flags read wrong");
a_read_other_miss: assert property (rd_en_i && !rd_flags |=> !rd_hit_o && rd_data_o == 8'h00)
    else $error("non-flags read answered");
a_flag_bit_map: assert property (global_interrupt_enable_o == flags_o[0] && super_o == flags_o[3]
    && register_bank_select_o == flags_o[4] && flags_o[7:5] == 3'h0) else $error("flag bit map wrong");
a_super_user_locked: assert property (!super_o && !super_enter_i |=> !super_o)
    else $error("user changed super bit");
a_super_enter_exit: assert property ((super_enter_i |=> super_o) and
    (super_exit_i && !super_enter_i && !flag_or_i && !flag_and_i |=> !super_o)) else $error("super bit wrong");
a_add_sum_carry: assert property (acc_wr && exec_i.op == CRS_OP_ADD && exec_i.set_flags
    |=> {flags_o[CRS_F_CARRY], acc_o} == $past(add_sum)) else $error("add result wrong");
a_zero_follows: assert property (acc_wr && exec_i.set_flags |=> flags_o[CRS_F_ZERO] == (acc_o == 8'h00))
    else $error("zero flag wrong");
a_acc_held: assert property (!acc_wr |=> $stable(acc_o))
    else $error("accumulator changed");
a_sp_push_step: assert property (!sp_ld && sp_act_i == CRS_SP_PUSH |=> sp_o == $past(sp_o) + 8'h01)
    else $error("push step wrong");
a_pc_load_shows: assert property (pc_cmd_i.load |-> ##2 {pc_high_o, pc_low_o} == $past(pc_cmd_i.target, 2))
    else $error("pc bytes wrong");
// Main scenarios reached
c_read_hit: cover property (rd_flags ##1 rd_hit_o);
c_super_enter: cover property (super_enter_i ##1 super_o);
c_pc_load: cover property (pc_cmd_i.load);
endmodule
bind crs_core_regs crs_core_regs_properties crs_core_regs_properties_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .exec_i(exec_i), .sp_act_i(sp_act_i), .pc_cmd_i(pc_cmd_i),
    .flag_and_i(flag_and_i), .flag_or_i(flag_or_i), .flag_operand_i(flag_operand_i),
    .super_enter_i(super_enter_i), .super_exit_i(super_exit_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o), .acc_o(acc_o), .idx_o(idx_o), .sp_o(sp_o),
    .pc_high_o(pc_high_o), .pc_low_o(pc_low_o), .flags_o(flags_o),
    .global_interrupt_enable_o(global_interrupt_enable_o),
    .register_bank_select_o(register_bank_select_o), .super_o(super_o));
`default_nettype wire

/* File: crs_core_regs_tb.sv */
/* Self-checking bench of the core register set.
   Drives every input at the falling clock edge. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module crs_core_regs_tb
    import crs_pkg::*;
;
logic clk_sys_i = 1'b0;
logic rst_n_i = 1'b0;
crs_exec_t ex = '0;
crs_sp_act_t sp_act = CRS_SP_HOLD;
crs_pc_cmd_t pc_cmd = '0;
logic f_and = 1'b0, f_or = 1'b0, s_in = 1'b0, s_out = 1'b0, rd_en = 1'b0;
logic [7:0] f_opnd = 8'h00, rd_addr = 8'h00, rd_data, acc, idx, sp, pch, pcl, flags, d;
logic rd_hit, gie, bank, sup, h;
int n_fail = 0, checked = 0;
crs_op_t ops[11] = '{CRS_OP_MOV, CRS_OP_AND, CRS_OP_OR, CRS_OP_XOR, CRS_OP_SUB, CRS_OP_ASL, CRS_OP_SBB,
    CRS_OP_RLC, CRS_OP_ASR, CRS_OP_ADC, CRS_OP_RRC};
logic [8:0] op_exp[11] = '{9'h00f, 9'h001, 9'h08f, 9'h08e, 9'h072, 9'h102, 9'h071, 9'h102, 9'h1c0, 9'h091,
    9'h140};
crs_sp_act_t acts[5] = '{CRS_SP_POP, CRS_SP_PUSH, CRS_SP_CALL, CRS_SP_RET, CRS_SP_RETURN_FROM_INTERRUPT_INSTRUCTION};
logic [7:0] sp_exp[5] = '{8'hff, 8'h00, 8'h02, 8'h00, 8'hfd};
////////////////////////////////////////////////////////////
// Clock
initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
end
// Design under test
crs_core_regs crs_core_regs_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .exec_i(ex), .sp_act_i(sp_act),
    .pc_cmd_i(pc_cmd), .flag_and_i(f_and), .flag_or_i(f_or), .flag_operand_i(f_opnd), .super_enter_i(s_in),
    .super_exit_i(s_out), .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_hit_o(rd_hit),
    .acc_o(acc), .idx_o(idx), .sp_o(sp), .pc_high_o(pch), .pc_low_o(pcl), .flags_o(flags),
    .global_interrupt_enable_o(gie), .register_bank_select_o(bank), .super_o(sup));
////////////////////////////////////////////////////////////
// Access tasks
task automatic step();
    @(negedge clk_sys_i);
endtask
task automatic run(input crs_op_t op, input crs_dst_t dst, input logic [7:0] a, input logic [7:0] b);
    ex = '{1'b1, op, dst, 1'b1, a, b};
    step();
    ex.valid = 1'b0;
    step();
endtask
task automatic rd(input logic [7:0] addr);
    rd_en = 1'b1;
    rd_addr = addr;
    step();
    rd_en = 1'b0;
    d = rd_data;
    h = rd_hit;
    step();
endtask
task automatic fl(input logic a, input logic o, input logic [7:0] v);
    f_and = a;
    f_or = o;
    f_opnd = v;
    step();
    f_and = 1'b0;
    f_or = 1'b0;
    step();
endtask
task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
////////////////////////////////////////////////////////////
// Watchdog
initial begin
    #8000;
    n_fail++;
    give_verdict();
end
// Test sequence
initial begin
    repeat (2) step();
    rst_n_i = 1'b1;
    `CHK({acc, idx, sp, pch, pcl, flags}, 48'h0000_0000_0002)
    step();
    rd(8'hf7);
    `CHK({h, d}, 9'h102)
    rd(8'hf6);
    `CHK({h, d}, 9'h000)
    run(CRS_OP_ADD, CRS_DST_ACC, 8'hff, 8'h01);
    `CHK({acc, flags}, 16'h0006)
    run(CRS_OP_ADD, CRS_DST_ACC, 8'h01, 8'h01);
    `CHK({acc, flags}, 16'h0200)
    for (int i = 0; i < 11; i++) begin
        run(ops[i], CRS_DST_ACC, 8'h81, 8'h0f);
        `CHK({flags[CRS_F_CARRY], acc}, op_exp[i])
    end
    for (int i = 0; i < 5; i++) begin
        sp_act = acts[i];
        step();
        sp_act = CRS_SP_HOLD;
        `CHK(sp, sp_exp[i])
        step();
    end
    run(CRS_OP_MOV, CRS_DST_IDX, 8'h00, 8'h5a);
    `CHK(idx, 8'h5a)
    sp_act = CRS_SP_PUSH;
    ex = '{1'b1, CRS_OP_MOV, CRS_DST_SP, 1'b1, 8'h00, 8'h40};
    step();
    ex.valid = 1'b0;
    sp_act = CRS_SP_HOLD;
    step();
    `CHK(sp, 8'h40)
    run(CRS_OP_ADD, CRS_DST_NONE, 8'h01, 8'h02);
    `CHK({acc, idx, sp}, 24'h405a40)
    pc_cmd = '{1'b1, 16'h1ffe, 1'b0, 2'h0};
    step();
    pc_cmd = '{1'b0, 16'h0000, 1'b1, 2'h2};
    step();
    pc_cmd = '0;
    `CHK({pch, pcl}, 16'h1ffe)
    step();
    `CHK({pch, pcl}, 16'h2000)
    fl(1'b1, 1'b0, 8'h00);
    `CHK(flags, 8'h00)
    fl(1'b0, 1'b1, 8'hff);
    `CHK({flags, gie, bank, sup}, 11'h0be)
    s_in = 1'b1;
    step();
    s_in = 1'b0;
    `CHK({flags, sup}, 9'h03f)
    fl(1'b1, 1'b0, 8'hf7);
    `CHK({flags, sup}, 9'h02e)
    s_in = 1'b1;
    step();
    s_in = 1'b0;
    s_out = 1'b1;
    step();
    s_out = 1'b0;
    `CHK({flags, sup}, 9'h02e)
    rd(8'hf7);
    `CHK({h, d}, 9'h117)
    fl(1'b1, 1'b0, 8'hfe);
    `CHK({flags, gie}, 9'h02c)
    fl(1'b0, 1'b1, 8'h08);
    `CHK({flags, sup}, 9'h02c)
    rst_n_i = 1'b0;
    repeat (2) step();
    rst_n_i = 1'b1;
    `CHK({acc, idx, sp, pch, pcl, flags}, 48'h0000_0000_0002)
    give_verdict();
end
endmodule
`default_nettype wire
